// >>> design/sbat_regs.svh
// Register offsets, field positions, reset values and counts for the arbiter
`ifndef SBAT_REGS_SVH
`define SBAT_REGS_SVH
`define SBAT_OFF_COUNT_LOW   12'h02C
`define SBAT_OFF_CONTROL     12'h030
`define SBAT_OFF_IRQ_STATUS  12'h034
`define SBAT_OFF_IRQ_MASK    12'h038
`define SBAT_IDX_COUNT_LOW   12'h00B
`define SBAT_CTL_MODE_LO     0
`define SBAT_CTL_MODE_HI     1
`define SBAT_CTL_LOST        2
`define SBAT_CTL_CLKSEL      3
`define SBAT_CTL_DONE        4
`define SBAT_CTL_RUN         5
`define SBAT_CTL_OVFL        6
`define SBAT_CTL_MSB         7
`define SBAT_IRQ_DONE        0
`define SBAT_IRQ_OVFL        1
`define SBAT_IRQ_LOST        2
`define SBAT_SAMPLE_SLOW     9'h038
`define SBAT_SAMPLE_FAST     9'h008
`define SBAT_RESET_BYTE      8'h00
`endif

// >>> design/sbat_pkg.sv
// Types shared by the arbiter modules
package sbat_pkg;
	typedef enum logic [1:0] {
		SBAT_MODE_IDLE    = 2'b00,
		SBAT_MODE_MEASURE = 2'b01,
		SBAT_MODE_ARB     = 2'b10,
		SBAT_MODE_RSVD    = 2'b11
	} sbat_mode_t;
	typedef enum logic [3:0] {
		SBAT_ST_IDLE = 4'b0001,
		SBAT_ST_WAIT = 4'b0010,
		SBAT_ST_RUN  = 4'b0100,
		SBAT_ST_STOP = 4'b1000
	} sbat_state_t;
endpackage : sbat_pkg

// >>> design/sbat_cnt_if.sv
// Counter control bundle between arbiter core and counter
`timescale 1ns/100ps
interface sbat_cnt_if;
	logic       clear;
	logic       advance;
	logic [8:0] count;
	logic       wrap;
	modport core (output clear, output advance, input count, input wrap);
	modport cnt  (input clear, input advance, output count, output wrap);
endinterface : sbat_cnt_if

// >>> design/sbat_counter.sv
// Nine-bit arbiter counter with overflow pulse
`timescale 1ns/100ps
`include "sbat_regs.svh"
module sbat_counter (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	sbat_cnt_if.cnt   bus
);
	import sbat_pkg::*;
	logic [8:0] count_reg;

	////////////////////////////////////////////////////////////////////////
	// Clear wins over advance; overflow pulses on wrap to zero
	// nine-bit count
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count_reg <= 9'h000;
		end else if (clk_en) begin
			if (bus.clear) begin
				count_reg <= 9'h000;
			end else if (bus.advance) begin
				count_reg <= count_reg + 9'h001;
			end
		end
	end

	assign bus.count = count_reg;
	assign bus.wrap  = bus.advance && !bus.clear && (count_reg == 9'h1FF);
endmodule : sbat_counter

// >>> design/sbat_arbiter.sv
// Serial bus arbiter timer: APB registers, measurement and arbitration
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "sbat_regs.svh"
module sbat_arbiter (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        prescale_tick,
	input  wire logic        rx_pin,
	input  wire logic        internal_transmit_out,
	output logic             tx_pin,
	output logic             irq
);
	import sbat_pkg::*;

	logic [1:0]  mode_reg;
	logic        clksel_reg;
	logic        lost_reg;
	logic        done_reg;
	logic        ovfl_reg;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_mask_reg;
	logic        rx_meta_reg;
	logic        rx_sync_reg;
	logic        rx_prev_reg;
	logic        tx_prev_reg;
	logic        half_reg;
	logic        seen_low_reg;
	sbat_state_t state_reg;
	sbat_state_t state_next;
	logic        wr_ctl;
	logic        wr_stat;
	logic        wr_mask;
	logic        rx_fall;
	logic        rx_rise;
	logic        tx_rise;
	logic        tick;
	logic        mode_enter;
	logic        sample_hit;
	logic [7:0]  ctl_rd;
	logic [2:0]  irq_set;
	sbat_cnt_if  cnt_bus ();

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait state, unmapped addresses read zero, error
	assign pready = 1'b1;
	assign wr_ctl  = psel && penable && pwrite
		&& (paddr == `SBAT_OFF_CONTROL);
	assign wr_stat = psel && penable && pwrite
		&& (paddr == `SBAT_OFF_IRQ_STATUS);
	assign wr_mask = psel && penable && pwrite
		&& (paddr == `SBAT_OFF_IRQ_MASK);

	assign ctl_rd = {cnt_bus.count[8], ovfl_reg,
		state_reg == SBAT_ST_RUN, done_reg, clksel_reg, lost_reg,
		mode_reg};

	// Read mux; data held in a flop per output style
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
		end else if (clk_en && psel && !penable) begin
			unique case (paddr)
				`SBAT_OFF_COUNT_LOW:  prdata <= {24'h0, cnt_bus.count[7:0]};
				`SBAT_OFF_CONTROL:    prdata <= {24'h0, ctl_rd};
				`SBAT_OFF_IRQ_STATUS: prdata <= {29'h0, irq_stat_reg};
				`SBAT_OFF_IRQ_MASK:   prdata <= {29'h0, irq_mask_reg};
				default:              prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Decode error on unmapped address
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			pslverr = !(paddr == `SBAT_OFF_COUNT_LOW
				|| paddr == `SBAT_OFF_CONTROL
				|| paddr == `SBAT_OFF_IRQ_STATUS
				|| paddr == `SBAT_OFF_IRQ_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive pin crosses in from the bus: two flops before use
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
			tx_prev_reg <= 1'b1;
		end else if (clk_en) begin
			rx_meta_reg <= rx_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
			tx_prev_reg <= internal_transmit_out;
		end
	end

	assign rx_fall = rx_prev_reg && !rx_sync_reg;
	assign rx_rise = !rx_prev_reg && rx_sync_reg;
	assign tx_rise = !tx_prev_reg && internal_transmit_out;

	////////////////////////////////////////////////////////////////////////
	// Half-rate divider; source chosen by the clock select bit
	// half bus or half prescaled clock
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			half_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctl) begin
				half_reg <= 1'b0;
			end else if (clksel_reg ? prescale_tick : 1'b1) begin
				half_reg <= !half_reg;
			end
		end
	end

	assign tick = half_reg && (clksel_reg ? prescale_tick : 1'b1);

	////////////////////////////////////////////////////////////////////////
	// Control fields; written whole on a control write
	// mode field select
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_reg   <= 2'b00;
			clksel_reg <= 1'b0;
		end else if (clk_en && wr_ctl) begin
			mode_reg   <= pwdata[`SBAT_CTL_MODE_HI:`SBAT_CTL_MODE_LO];
			clksel_reg <= pwdata[`SBAT_CTL_CLKSEL];
		end
	end

	assign mode_enter = wr_ctl;

	////////////////////////////////////////////////////////////////////////
	// Sequencer for measurement and arbitration
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SBAT_ST_IDLE: begin
				if (mode_reg == SBAT_MODE_MEASURE
					|| mode_reg == SBAT_MODE_ARB) begin
					state_next = SBAT_ST_WAIT;
				end
			end
			SBAT_ST_WAIT: begin
				if (mode_reg == SBAT_MODE_MEASURE) begin
					if (clksel_reg ? !rx_sync_reg : rx_fall) begin
						state_next = SBAT_ST_RUN;
					end
				end else if (mode_reg == SBAT_MODE_ARB) begin
					if (tx_rise) begin
						state_next = SBAT_ST_RUN;
					end
				end
			end
			SBAT_ST_RUN: begin
				if (cnt_bus.wrap) begin
					state_next = SBAT_ST_STOP;
				end else if (mode_reg == SBAT_MODE_MEASURE) begin
					if (clksel_reg ? rx_rise : rx_fall) begin
						state_next = SBAT_ST_STOP;
					end
				end else if (mode_reg == SBAT_MODE_ARB
					&& !internal_transmit_out && !seen_low_reg) begin
					state_next = SBAT_ST_WAIT;
				end
			end
			SBAT_ST_STOP: state_next = SBAT_ST_STOP;
			default:      state_next = SBAT_ST_IDLE;
		endcase
		if (mode_enter || mode_reg == SBAT_MODE_IDLE
			|| mode_reg == SBAT_MODE_RSVD) begin
			state_next = SBAT_ST_IDLE;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= SBAT_ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter drive; any control write clears the count
	// count frozen outside run
	assign cnt_bus.clear = wr_ctl || state_reg == SBAT_ST_IDLE
		|| (state_reg == SBAT_ST_RUN && state_next == SBAT_ST_WAIT)
		|| (state_reg == SBAT_ST_RUN && mode_reg == SBAT_MODE_ARB
			&& tx_rise);
	assign cnt_bus.advance = clk_en && state_reg == SBAT_ST_RUN && tick;

	sbat_counter u_counter (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.bus      (cnt_bus.cnt)
	);

	assign sample_hit = state_reg == SBAT_ST_RUN && mode_reg == SBAT_MODE_ARB
		&& cnt_bus.count == (clksel_reg ? `SBAT_SAMPLE_FAST
			: `SBAT_SAMPLE_SLOW);

	////////////////////////////////////////////////////////////////////////
	// Status flags; set wins over a same-cycle clear
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lost_reg     <= 1'b0;
			done_reg     <= 1'b0;
			ovfl_reg     <= 1'b0;
			seen_low_reg <= 1'b0;
		end else if (clk_en) begin
			if (cnt_bus.wrap) begin
				ovfl_reg <= 1'b1;
			end else if (wr_ctl) begin
				ovfl_reg <= 1'b0;
			end
			if (state_reg == SBAT_ST_RUN && state_next == SBAT_ST_STOP
				&& mode_reg == SBAT_MODE_MEASURE) begin
				done_reg <= 1'b1;
			end else if (wr_ctl) begin
				done_reg <= 1'b0;
			end
			if (sample_hit && !rx_sync_reg) begin
				lost_reg <= 1'b1;
			end else if (wr_ctl && !pwdata[`SBAT_CTL_MODE_HI]) begin
				lost_reg <= 1'b0;
			end
			if (!rx_sync_reg && state_reg == SBAT_ST_RUN) begin
				seen_low_reg <= 1'b1;
			end else if (state_reg != SBAT_ST_RUN || tx_rise) begin
				seen_low_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_pin <= 1'b1;
		end else if (clk_en) begin
			tx_pin <= internal_transmit_out
				|| lost_reg || (sample_hit && !rx_sync_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear, masked level output
	always_comb begin
		irq_set = 3'b000;
		irq_set[`SBAT_IRQ_DONE] = state_reg == SBAT_ST_RUN
			&& state_next == SBAT_ST_STOP && mode_reg == SBAT_MODE_MEASURE;
		irq_set[`SBAT_IRQ_OVFL] = cnt_bus.wrap;
		irq_set[`SBAT_IRQ_LOST] = sample_hit && !rx_sync_reg;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= 3'b000;
			irq_mask_reg <= 3'b000;
		end else if (clk_en) begin
			irq_stat_reg <= irq_set | (irq_stat_reg
				& ~(wr_stat ? pwdata[2:0] : 3'b000));
			if (wr_mask) begin
				irq_mask_reg <= pwdata[2:0];
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_lost_forces_tx;
		@(posedge core_clk) disable iff (reset)
		(clk_en && lost_reg) |=> tx_pin;
	endproperty
	a_lost_forces_tx: assert property (p_lost_forces_tx)
		else $error("transmit pin low while lost flag set");

	property p_ctl_write_clears;
		@(posedge core_clk) disable iff (reset)
		(clk_en && wr_ctl && !cnt_bus.wrap) |=> !ovfl_reg && !done_reg
			&& cnt_bus.count == 9'h000;
	endproperty
	a_ctl_write_clears: assert property (p_ctl_write_clears)
		else $error("control write did not clear flags and count");

	property p_idle_holds;
		@(posedge core_clk) disable iff (reset)
		(mode_reg == SBAT_MODE_IDLE) [*2] |-> cnt_bus.count == 9'h000
			&& state_reg == SBAT_ST_IDLE;
	endproperty
	a_idle_holds: assert property (p_idle_holds)
		else $error("counter not held in idle mode");

	sequence s_lost_sample;
		clk_en && sample_hit && !rx_sync_reg;
	endsequence
	property p_lost_set;
		@(posedge core_clk) disable iff (reset)
		s_lost_sample |=> lost_reg;
	endproperty
	a_lost_set: assert property (p_lost_set)
		else $error("low sample did not set lost flag");

	property p_stop_stable;
		@(posedge core_clk) disable iff (reset)
		(state_reg == SBAT_ST_STOP && !wr_ctl)
			|=> $stable(cnt_bus.count);
	endproperty
	a_stop_stable: assert property (p_stop_stable)
		else $error("captured count changed after stop");

	property p_wrap_stops;
		@(posedge core_clk) disable iff (reset)
		(clk_en && cnt_bus.wrap) |=> ovfl_reg
			&& state_reg != SBAT_ST_RUN;
	endproperty
	a_wrap_stops: assert property (p_wrap_stops)
		else $error("counter kept running after overflow");

	property p_done_on_stop;
		@(posedge core_clk) disable iff (reset)
		(clk_en && irq_set[`SBAT_IRQ_DONE]) |=> done_reg
			&& ctl_rd[`SBAT_CTL_RUN] == 1'b0;
	endproperty
	a_done_on_stop: assert property (p_done_on_stop)
		else $error("measurement stop did not set done flag");

	property p_irq_level;
		@(posedge core_clk) disable iff (reset)
		(irq_stat_reg & irq_mask_reg) != 3'b000 |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt low with pending unmasked bit");
endmodule : sbat_arbiter

// >>> bench/sbat_bus_node.sv
// Shared serial bus model: this node plus one other transmitting node
`timescale 1ns/100ps
module sbat_bus_node (
	input  wire logic tx_pin,
	input  wire logic other_low,
	output logic      rx_pin
);
	// Open-drain bus with pull-up: any node driving low wins the line
	assign rx_pin = tx_pin & ~other_low;
endmodule : sbat_bus_node

// >>> bench/tb_serial_bus_arbiter_timer.sv
// Self-checking bench for the serial bus arbiter timer
`timescale 1ns/100ps
`include "sbat_regs.svh"
`define CHECK(w, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("BAD %s exp %0h got %0h", w, e, g); \
	end \
end
module tb_serial_bus_arbiter_timer;
	import sbat_pkg::*;
	localparam logic [11:0] A_CTL = `SBAT_OFF_CONTROL;
	localparam logic [11:0] A_LOW = `SBAT_OFF_COUNT_LOW;
	localparam logic [11:0] A_STS = `SBAT_OFF_IRQ_STATUS;
	localparam logic [11:0] A_MSK = `SBAT_OFF_IRQ_MASK;
	logic        core_clk;
	logic        reset;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        prescale_tick;
	logic [1:0]  tick_div;
	logic        rx_pin;
	logic        internal_transmit_out;
	logic        tx_pin;
	logic        irq;
	logic        other_low;
	logic [31:0] rd;
	logic [31:0] keep;
	logic        err;
	int          cycles;
	int          miscompares;
	int          n_compared;
	////////////////////////////////////////////////////////////////////
	sbat_arbiter i_dut (
		.core_clk              (core_clk),
		.reset                 (reset),
		.clk_en                (clk_en),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.prescale_tick         (prescale_tick),
		.rx_pin                (rx_pin),
		.internal_transmit_out (internal_transmit_out),
		.tx_pin                (tx_pin),
		.irq                   (irq)
	);
	sbat_bus_node i_bus (
		.tx_pin    (tx_pin),
		.other_low (other_low),
		.rx_pin    (rx_pin)
	);
	////////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Prescaler tick every fourth cycle, so ACLK=1 counts every 8
	always @(posedge core_clk) begin
		tick_div <= tick_div + 2'h1;
		prescale_tick <= (tick_div == 2'h3);
	end
	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////
	// Idle cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	// One APB transfer; request held until pready seen high or 16 access cycles pass
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Other node pulls the bus low for n cycles
	task automatic fall(input int n);
		other_low <= 1'b1;
		cyc(n);
		other_low <= 1'b0;
	endtask : fall
	////////////////////////////////////////////////////////////////////
	// Reset values and an unmapped access
	task automatic t_reset;
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("ctl", 32'h0, rd)
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("low", 32'h0, rd)
		apb(1'b0, 12'h0FC, 32'h0);
		`CHECK("unmapped", 1'b1, err)
		`CHECK("tx", 1'b1, tx_pin)
		`CHECK("irq", 1'b0, irq)
	endtask : t_reset
	// Fall-to-fall over 600 cycles: count 300 needs the top bit
	task automatic t_fall;
		apb(1'b1, A_CTL, 32'h01);
		cyc(10);
		fall(20);
		cyc(20);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("run", 1'b1, rd[`SBAT_CTL_RUN])
		cyc(557);
		fall(10);
		cyc(10);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("ctl", 8'h91, rd[7:0])
		apb(1'b0, A_LOW, 32'h0);
		keep = rd;
		`CHECK("low", 1'b1, rd[7:0] inside {[8'h2B:8'h2D]})
		cyc(30);
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("held", keep, rd)
		// Mask and status land at the access edge: let irq settle
		apb(1'b1, A_MSK, 32'h01);
		cyc(1);
		`CHECK("irq on", 1'b1, irq)
		apb(1'b1, A_STS, 32'h01);
		cyc(1);
		`CHECK("irq off", 1'b0, irq)
		apb(1'b1, A_CTL, 32'h01);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("ctl clr", 8'h01, rd[7:0])
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("low clr", 32'h0, rd)
	endtask : t_fall
	// No second fall: counter overflows, stops, then mode 00 idles
	task automatic t_ovfl;
		fall(10);
		cyc(1200);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("ovfl", 2'b10, rd[6:5])
		apb(1'b0, A_LOW, 32'h0);
		keep = rd;
		cyc(40);
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("stopped", keep, rd)
		apb(1'b0, A_STS, 32'h0);
		`CHECK("ovfl sts", 1'b1, rd[`SBAT_IRQ_OVFL])
		apb(1'b1, A_CTL, 32'h00);
		fall(10);
		cyc(50);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("idle ctl", 32'h0, rd)
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("idle low", 32'h0, rd)
	endtask : t_ovfl
	// Break already low at enable, ACLK=1: about 400 / 8 counts
	task automatic t_break;
		other_low <= 1'b1;
		cyc(10);
		apb(1'b1, A_CTL, 32'h09);
		cyc(400);
		other_low <= 1'b0;
		cyc(20);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("ctl", 8'h19, rd[7:0])
		apb(1'b0, A_LOW, 32'h0);
		`CHECK("low", 1'b1, rd[7:0] inside {[8'h30:8'h34]})
		apb(1'b1, A_CTL, 32'h00);
	endtask : t_break
	// Arbitration: other node low over a window after transmit rise
	task automatic t_arb(input logic [31:0] c, input int st,
		input int len, input logic lost);
		apb(1'b1, A_STS, 32'h07);
		apb(1'b1, A_MSK, 32'h04);
		apb(1'b1, A_CTL, c);
		internal_transmit_out <= 1'b0;
		cyc(4);
		internal_transmit_out <= 1'b1;
		cyc(st);
		fall(len);
		cyc(4);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("lost", lost, rd[`SBAT_CTL_LOST])
		`CHECK("irq", lost, irq)
		internal_transmit_out <= 1'b0;
		cyc(3);
		`CHECK("tx", lost, tx_pin)
		internal_transmit_out <= 1'b1;
		apb(1'b1, A_CTL, c & 32'hFD);
		apb(1'b0, A_CTL, 32'h0);
		`CHECK("lost clr", 1'b0, rd[`SBAT_CTL_LOST])
	endtask : t_arb
	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic give_verdict;
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		tick_div = 2'h0;
		prescale_tick = 1'b0;
		internal_transmit_out = 1'b1;
		other_low = 1'b0;
		cycles = 0;
		miscompares = 0;
		n_compared = 0;
		cyc(5);
		reset <= 1'b0;
		t_reset();
		t_fall();
		t_ovfl();
		t_break();
		t_arb(32'h02, 130, 70, 1'b0);
		t_arb(32'h02, 80, 80, 1'b1);
		t_arb(32'h0A, 5, 30, 1'b0);
		t_arb(32'h0A, 40, 80, 1'b1);
		give_verdict();
	end
endmodule : tb_serial_bus_arbiter_timer
